// ==== dv/stop_recovery_port_cfg_regs_test.sv ====
`timescale 1ns/1ps
module stop_recovery_port_cfg_regs_test
  import regs_pkg::*;
;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [3:0]  address = 4'h0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic        recovery_exit = 1'b0;
  logic [31:0] readdata;
  logic [31:0] rd_seen = 32'h0;
  logic        waitrequest;
  logic        port0_push_pull;
  logic [7:0]  port3_mode;
  logic        recovery_pol_high;
  logic        recovery_long_delay;
  logic [2:0]  recovery_source;
  logic        clk_div16;
  logic        timer_clock_en;
  logic [15:0] stack_ptr;
  logic        irq;
  int          err_total = 0;
  int          n_tests = 0;

  // 25 MHz clock
  always #20 clk = ~clk;

  stop_recovery_port_cfg_regs uut (
    .clk(clk), .nrst(nrst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .recovery_exit(recovery_exit),
    .port0_push_pull(port0_push_pull), .port3_mode(port3_mode),
    .recovery_pol_high(recovery_pol_high),
    .recovery_long_delay(recovery_long_delay),
    .recovery_source(recovery_source), .clk_div16(clk_div16),
    .timer_clock_en(timer_clock_en), .stack_ptr(stack_ptr), .irq(irq)
  );

  task automatic tally_and_finish();
    if (err_total == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask

  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= {24'h0, d};
    write <= wr;
    read <= ~wr;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 20);
    rd_seen = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0)
    begin
      err_total++;
      tally_and_finish();
    end
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic rd(input string what, input logic [3:0] a,
                    input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    chk(what, exp, rd_seen);
  endtask

  task automatic do_reset();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    #1;
  endtask

  // Port 0 mode and port 3 mode, both write-only
  task automatic t_ports();
    bus(1'b1, ADDR_PCFG, 8'hfb);
    chk("push_pull", 32'h0, {31'h0, port0_push_pull});
    bus(1'b1, ADDR_PCFG, 8'h04);
    chk("push_pull", 32'h1, {31'h0, port0_push_pull});
    rd("pcfg_rd", ADDR_PCFG, 32'h0);
    bus(1'b1, ADDR_PORT3, 8'ha5);
    chk("port3", 32'ha5, {24'h0, port3_mode});
    rd("port3_rd", ADDR_PORT3, 32'h0);
  endtask

  // Every source code with polarity, delay and divide fields
  task automatic t_fields();
    logic [2:0] s;
    for (int i = 0; i < 8; i++)
    begin
      s = 3'(i);
      bus(1'b1, ADDR_SRC, {1'b1, s[0], ~s[0], s, 1'b1, s[1]});
      chk("fields", {26'h0, s[0], ~s[0], s, s[1]}, {26'h0,
          recovery_pol_high, recovery_long_delay, recovery_source,
          clk_div16});
      rd("src_rd", ADDR_SRC, 32'h0);
    end
    bus(1'b1, ADDR_PCFG, 8'h00);
    chk("held", 32'h2f, {26'h0, recovery_pol_high, recovery_long_delay,
        recovery_source, clk_div16});
  endtask

  // Timer clock enable counted over 32 cycles
  task automatic t_divide(input logic div, input int exp);
    int c;
    c = 0;
    bus(1'b1, ADDR_SRC, {7'h00, div});
    repeat (32)
    begin
      @(posedge clk);
      #1;
      if (timer_clock_en === 1'b1)
        c++;
    end
    chk("timer_clock_count", 32'(exp), 32'(c));
  endtask

  // Recovery flag, event status, mask and interrupt
  task automatic t_exit();
    bus(1'b1, ADDR_MASK, 8'h00);
    @(posedge clk);
    recovery_exit <= 1'b1;
    @(posedge clk);
    recovery_exit <= 1'b0;
    repeat (2) @(posedge clk);
    rd("flag", ADDR_SRC, 32'h80);
    rd("status", ADDR_STAT, 32'h1);
    chk("irq_masked", 32'h0, {31'h0, irq});
    bus(1'b1, ADDR_MASK, 8'h01);
    chk("irq_on", 32'h1, {31'h0, irq});
    bus(1'b1, ADDR_SRC, 8'h00);
    rd("flag_kept", ADDR_SRC, 32'h80);
    bus(1'b1, ADDR_STAT, 8'h01);
    chk("irq_off", 32'h0, {31'h0, irq});
    rd("status_clr", ADDR_STAT, 32'h0);
    do_reset();
    rd("flag_por", ADDR_SRC, 32'h0);
  endtask

  // Stack pointer bytes and the unused slot
  task automatic t_stack();
    bus(1'b1, ADDR_STK_HI, 8'h12);
    bus(1'b1, ADDR_STK_LO, 8'h34);
    chk("stack_ptr", 32'h1234, {16'h0, stack_ptr});
    rd("stk_hi_rd", ADDR_STK_HI, 32'h12);
    rd("stk_lo_rd", ADDR_STK_LO, 32'h34);
    rd("unused", ADDR_EVENT, 32'h0);
  endtask

  initial
  begin
    do_reset();
    chk("reset_outs", 32'h0, {port0_push_pull, port3_mode,
        recovery_pol_high, recovery_long_delay, recovery_source,
        clk_div16, stack_ptr, irq});
    chk("reset_wait", 32'h1, {31'h0, waitrequest});
    t_ports();
    t_fields();
    t_divide(1'b0, 32);
    t_divide(1'b1, 2);
    t_exit();
    t_stack();
    tally_and_finish();
  end
endmodule

// ==== logic/reg_store.sv ====
`timescale 1ns/1ps
// Small register store, read data registered
module reg_store
  import regs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       wr_en,
  input  wire logic [2:0] wr_idx,
  input  wire logic [7:0] wr_data,
  input  wire logic [2:0] rd_idx,
  output logic      [7:0] rd_data,
  output logic      [7:0] q_all [NUM_REGS]
);
  logic [7:0] mem      [NUM_REGS];
  logic [7:0] next_mem [NUM_REGS];
  logic [7:0] next_rd;

  // Next contents, hold until written
  always_comb
  begin
    next_mem = mem;
    if (wr_en)
    begin
      next_mem[wr_idx] = wr_data;
    end
    next_rd = next_mem[rd_idx];
  end

  // Register stage
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < NUM_REGS; i++)
      begin
        mem[i] <= RST_BYTE;
      end
      rd_data <= RST_BYTE;
    end
    else
    begin
      mem     <= next_mem;
      rd_data <= next_rd;
    end
  end

  assign q_all = mem;
endmodule

// ==== logic/regs_pkg.sv ====
// Overview of operation
// - Port 0 config bit 2 selects push-pull
// - Recovery control write-only except readable bit 7
// - Recovery flag set on exit, cleared by power-on
// - Bit 6 sets recovery level polarity
// - Bit 5 selects post-recovery reset delay
// - Bits 4..2 select recovery source
// - Bit 0 divides system and timer clock
// - Recovery control sits at bank F 0bh
// - Stack pointer high FEh, low FFh, read/write
// - Port 3 mode at F7h, write-only
// - Port config at bank F 00h, write-only
package regs_pkg;
  // Word addresses, one consecutive index per register
  localparam logic [3:0] ADDR_PCFG   = 4'h0; // Bank F 00h
  localparam logic [3:0] ADDR_SRC    = 4'h1; // Bank F 0bh
  localparam logic [3:0] ADDR_PORT3  = 4'h2; // F7h
  localparam logic [3:0] ADDR_STK_HI = 4'h3; // FEh
  localparam logic [3:0] ADDR_STK_LO = 4'h4; // FFh
  localparam logic [3:0] ADDR_STAT   = 4'h5;
  localparam logic [3:0] ADDR_MASK   = 4'h6;
  localparam logic [3:0] ADDR_EVENT  = 4'h7;
  localparam logic [7:0] IDX_PCFG    = 8'h00;
  localparam logic [7:0] IDX_SRC     = 8'h0b;
  localparam logic [7:0] IDX_PORT3   = 8'hf7;
  localparam logic [7:0] IDX_STK_HI  = 8'hfe;
  localparam logic [7:0] IDX_STK_LO  = 8'hff;
  localparam int P0_MODE_BIT  = 2;
  localparam int FLAG_BIT     = 7;
  localparam int POL_BIT      = 6;
  localparam int DELAY_BIT    = 5;
  localparam int SRC_LSB      = 2;
  localparam int DIV_BIT      = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] DIV_LAST = 4'hf; // Divide by 16
  localparam int NUM_REGS     = 8;

  typedef struct packed {
    logic       pol_high;
    logic       long_delay;
    logic [2:0] source;
    logic       div16;
  } recovery_cfg_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DONE = 2'b10
  } bus_state_t;
endpackage

// ==== logic/stop_recovery_port_cfg_regs.sv ====
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps
// Register bank for recovery control, port config and stack pointer
module stop_recovery_port_cfg_regs
  import regs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        recovery_exit,
  output logic             port0_push_pull,
  output logic      [7:0]  port3_mode,
  output logic             recovery_pol_high,
  output logic             recovery_long_delay,
  output logic      [2:0]  recovery_source,
  output logic             clk_div16,
  output logic             timer_clock_en,
  output logic      [15:0] stack_ptr,
  output logic             irq
);
  bus_state_t state;
  bus_state_t next_state;
  logic       flag;
  logic       next_flag;
  logic       stat;
  logic       next_stat;
  logic       mask;
  logic       next_mask;
  logic [3:0] div_cnt;
  logic [3:0] next_div_cnt;
  logic       next_timer_en;
  logic [31:0] next_readdata;
  logic       st_wr;
  logic [2:0] st_idx;
  logic [7:0] st_q [NUM_REGS];
  recovery_cfg_t cfg;

  // Store slot for a bus address; -1 style 7 means no slot
  function automatic logic [2:0] slot(input logic [3:0] a);
    unique case (a)
      ADDR_PCFG: slot = 3'h0;
      ADDR_SRC:    slot = 3'h1;
      ADDR_PORT3:  slot = 3'h2;
      ADDR_STK_HI: slot = 3'h3;
      ADDR_STK_LO: slot = 3'h4;
      default:   slot = 3'h7;
    endcase
  endfunction

  // Store writes land at the edge where waitrequest is low
  assign st_idx = slot(address);
  assign st_wr  = (state == BUS_DONE) && write && (st_idx != 3'h7);

  reg_store u_store (
    .clk     (clk),
    .nrst    (nrst),
    .wr_en   (st_wr),
    .wr_idx  (st_idx),
    .wr_data (writedata[7:0]),
    .rd_idx  (st_idx),
    .rd_data (),
    .q_all   (st_q)
  );

  // Decode of recovery control byte, held bits drive logic
  always_comb
  begin
    cfg.pol_high   = st_q[1][POL_BIT];
    cfg.long_delay = st_q[1][DELAY_BIT];
    cfg.source     = st_q[1][SRC_LSB +: 3];
    cfg.div16      = st_q[1][DIV_BIT];
  end

  // Bus handshake: read data loaded in the wait cycle, writes land at done
  always_comb
  begin
    next_state    = state;
    next_readdata = readdata;
    next_mask     = mask;
    unique case (state)
      BUS_IDLE:
      begin
        if (read || write)
        begin
          next_state = BUS_DONE;
        end
      end
      BUS_DONE:
      begin
        next_state = BUS_IDLE;
        if (write && address == ADDR_MASK)
        begin
          next_mask = writedata[0];
        end
      end
    endcase
    // Read data stand at the edge where waitrequest is low
    if (state == BUS_IDLE && read)
    begin
      unique case (address)
        ADDR_SRC:    next_readdata = {24'h0, flag, 7'h0};
        ADDR_STK_HI: next_readdata = {24'h0, st_q[3]};
        ADDR_STK_LO: next_readdata = {24'h0, st_q[4]};
        ADDR_STAT: next_readdata = {31'h0, stat};
        ADDR_MASK: next_readdata = {31'h0, mask};
        default:   next_readdata = 32'h0;
      endcase
    end
  end

  // Recovery flag, only reset clears it; sticky event status
  always_comb
  begin
    next_flag = flag | recovery_exit;
    next_stat = stat;
    if (state == BUS_DONE && write && address == ADDR_STAT
        && writedata[0])
    begin
      next_stat = 1'b0;
    end
    if (recovery_exit)
    begin
      next_stat = 1'b1; // Set wins over clear
    end
  end

  // Divide by 16 for timer clock enable
  always_comb
  begin
    next_div_cnt = div_cnt + 4'h1;
    next_timer_en = cfg.div16 ? (div_cnt == DIV_LAST) : 1'b1;
  end

  // Bus, flag, status, mask, divider and irq registers
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state          <= BUS_IDLE;
      readdata       <= 32'h0;
      flag           <= 1'b0;
      stat           <= 1'b0;
      mask           <= 1'b0;
      div_cnt        <= 4'h0;
      timer_clock_en <= 1'b0;
      irq            <= 1'b0;
    end
    else
    begin
      state          <= next_state;
      readdata       <= next_readdata;
      flag           <= next_flag;
      stat           <= next_stat;
      mask           <= next_mask;
      div_cnt        <= next_div_cnt;
      timer_clock_en <= next_timer_en;
      irq            <= next_stat & next_mask;
    end
  end

  // Output registers following the store
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      port0_push_pull     <= 1'b0;
      port3_mode          <= RST_BYTE;
      recovery_pol_high   <= 1'b0;
      recovery_long_delay <= 1'b0;
      recovery_source     <= 3'h0;
      clk_div16           <= 1'b0;
      stack_ptr           <= 16'h0;
    end
    else
    begin
      port0_push_pull     <= st_q[0][P0_MODE_BIT];
      port3_mode          <= st_q[2];
      recovery_pol_high   <= cfg.pol_high;
      recovery_long_delay <= cfg.long_delay;
      recovery_source     <= cfg.source;
      clk_div16           <= cfg.div16;
      stack_ptr           <= {st_q[3], st_q[4]};
    end
  end

  assign waitrequest = (state == BUS_IDLE);

  // Checks
  a_flag_sticky: assert property (@(posedge clk) disable iff (!nrst)
    recovery_exit |=> flag)
    else $error("recovery flag not set");
  a_flag_hold: assert property (@(posedge clk) disable iff (!nrst)
    $past(flag) |-> flag)
    else $error("recovery flag cleared without reset");
  a_p0_mode: assert property (@(posedge clk) disable iff (!nrst)
    st_wr && st_idx == 3'h0 |=> ##1
    port0_push_pull == $past(writedata[P0_MODE_BIT], 2))
    else $error("port 0 mode wrong");
  a_src_read_flag: assert property (@(posedge clk) disable iff (!nrst)
    state == BUS_IDLE && read && address == ADDR_SRC |=>
    readdata == {24'h0, $past(flag), 7'h0})
    else $error("recovery control read wrong");
  a_port3_read_zero: assert property (@(posedge clk) disable iff (!nrst)
    state == BUS_IDLE && read && address == ADDR_PORT3 |=>
    readdata == 32'h0)
    else $error("port 3 mode readable");
  a_pcfg_read_zero: assert property (@(posedge clk) disable iff (!nrst)
    state == BUS_IDLE && read && address == ADDR_PCFG |=>
    readdata == 32'h0)
    else $error("port config readable");
  a_stk_lo_round: assert property (@(posedge clk) disable iff (!nrst)
    st_wr && st_idx == 3'h4 |=> ##1
    stack_ptr[7:0] == $past(writedata[7:0], 2))
    else $error("stack low wrong");
  a_src_fields: assert property (@(posedge clk) disable iff (!nrst)
    st_wr && st_idx == 3'h1 |=> ##1
    recovery_source == $past(writedata[4:2], 2)
    && recovery_pol_high == $past(writedata[6], 2)
    && recovery_long_delay == $past(writedata[5], 2))
    else $error("recovery fields wrong");
  a_div_pass: assert property (@(posedge clk) disable iff (!nrst)
    !cfg.div16 |=> timer_clock_en)
    else $error("undivided clock gated");
  a_hold_cfg: assert property (@(posedge clk) disable iff (!nrst)
    !st_wr ##1 !st_wr |=> $stable(clk_div16))
    else $error("config changed without write");
  a_delay_bit: assert property (@(posedge clk) disable iff (!nrst)
    ##1 recovery_long_delay == $past(cfg.long_delay))
    else $error("delay bit mismatch");
  a_pol_bit: assert property (@(posedge clk) disable iff (!nrst)
    ##1 recovery_pol_high == $past(cfg.pol_high))
    else $error("polarity bit mismatch");

  c_recovery: cover property (@(posedge clk) disable iff (!nrst)
    recovery_exit ##1 flag);
  c_irq: cover property (@(posedge clk) disable iff (!nrst) irq);
  c_sp_read: cover property (@(posedge clk) disable iff (!nrst)
    read && address == ADDR_STK_LO && !waitrequest);
  c_div: cover property (@(posedge clk) disable iff (!nrst)
    clk_div16 && timer_clock_en);
endmodule
